// ===== design/qec_counter.sv
// quadrature encoder counter with index handling and avalon registers
// Operation
// - each A/B edge adds or subtracts constant unless A and B change in the same clock
// - constant is signed 16.16 fixed point
// - decimal mode fraction 0..9999, carry 10000
// - negative decimal fraction is 10000 minus digits
// - negative constant reverses counting direction
// - continuous bit acts on every accepted index
// - single-shot acts once then disables itself
// - index accepted only when A/B match qualifiers
// - clear needs clear-enable plus once or continuous
// - accepted index copies position to capture only when once or continuous is set
// - status records index-triggered clear
// - position readable any time
// - filter A, B, index over three clocks
// - deviation beyond limit raises interrupt
// - inputs routed only when encoder selected
// - counting works without index input
`default_nettype none
module qec_counter (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic enc_a_i,
   input wire logic enc_b_i,
   input wire logic enc_n_i,
   input wire logic [qec_pkg::QEC_AW-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic irq_o
);
   import qec_pkg::*;

   qec_bus_state_t bus_q;
   logic [31:0] rdata_q;
   logic [0:0] global_config_q;
   logic [QEC_ECF_W-1:0] encoder_config_q;
   logic [31:0] scale_q;
   logic [31:0] dev_limit_q;
   logic [31:0] motor_pos_q;
   logic [QEC_IRQ_W-1:0] irq_status_q;
   logic [QEC_IRQ_W-1:0] irq_mask_q;
   logic [31:0] pos_int_q;
   logic [15:0] pos_frac_q;
   logic [31:0] capture_q;
   logic [2:0] prev_q;
   logic dev_q;

   qec_filt_if ch ();

   assign ch.raw = global_config_q[QEC_GCF_ENC_SEL] ? {enc_n_i, enc_b_i, enc_a_i} : 3'h0;

   // gating ahead of the synchroniser keeps a deselected mux quiet
   qec_input_filter #(
      .FILT_CYC(QEC_FILT_CYC)
   ) u_filt (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .ch(ch)
   );

   function automatic logic [31:0] qec_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return r;
   endfunction : qec_merge

   logic a_f;
   logic b_f;
   logic n_f;
   logic a_chg;
   logic b_chg;
   logic step;
   logic up;
   assign a_f = ch.clean[0];
   assign b_f = ch.clean[1];
   assign n_f = ch.clean[2];
   assign a_chg = a_f ^ prev_q[0];
   assign b_chg = b_f ^ prev_q[1];
   assign step = a_chg ^ b_chg;
   // a change on A against unchanged B: A leads when new A differs from B
   assign up = a_chg ? (a_f != b_f) : (a_f == b_f);

   logic [31:0] delta;
   logic [31:0] delta_int;
   logic [15:0] delta_frac;
   logic [31:0] sx_int;
   logic [16:0] bin_sum;
   logic [16:0] dec_sum;
   logic [31:0] nxt_int;
   logic [15:0] nxt_frac;
   always_comb begin
      delta = up ? scale_q : 32'(-scale_q);
      delta_int = {{16{delta[31]}}, delta[31:16]};
      delta_frac = delta[15:0];
      sx_int = delta_int;
      bin_sum = {1'b0, pos_frac_q} + {1'b0, delta_frac};
      dec_sum = 17'h0;
      nxt_int = pos_int_q;
      nxt_frac = pos_frac_q;
      if (encoder_config_q[QEC_ECF_DECIMAL]) begin
         if (up) begin
            dec_sum = {1'b0, pos_frac_q} + {1'b0, scale_q[15:0]};
            sx_int = {{16{scale_q[31]}}, scale_q[31:16]};
         end else begin
            // subtract: add 10000 minus digits, borrow one from the integer
            dec_sum = {1'b0, pos_frac_q} + {1'b0, QEC_DEC_BASE - scale_q[15:0]};
            sx_int = 32'(~{{16{scale_q[31]}}, scale_q[31:16]});
            if (scale_q[15:0] == 16'h0) begin
               dec_sum = {1'b0, pos_frac_q};
               sx_int = 32'(-{{16{scale_q[31]}}, scale_q[31:16]});
            end
         end
         if (dec_sum >= {1'b0, QEC_DEC_BASE}) begin
            nxt_frac = 16'(dec_sum - {1'b0, QEC_DEC_BASE});
            nxt_int = pos_int_q + sx_int + 32'h1;
         end else begin
            nxt_frac = dec_sum[15:0];
            nxt_int = pos_int_q + sx_int;
         end
      end else begin
         nxt_frac = bin_sum[15:0];
         nxt_int = pos_int_q + delta_int + {31'h0, bin_sum[16]};
      end
   end

   logic idx_edge;
   logic idx_ok;
   logic idx_act;
   logic do_clear;
   assign idx_edge = (n_f != prev_q[2]) && (n_f == encoder_config_q[QEC_ECF_POL_N]);
   assign idx_ok = idx_edge && (a_f == encoder_config_q[QEC_ECF_POL_A])
      && (b_f == encoder_config_q[QEC_ECF_POL_B]);
   assign idx_act = idx_ok && (encoder_config_q[QEC_ECF_CLR_CONT] || encoder_config_q[QEC_ECF_CLR_ONCE]);
   assign do_clear = idx_act && encoder_config_q[QEC_ECF_CLR_POS];

   logic wr_hit;
   assign wr_hit = (bus_q == QEC_BUS_IDLE) && avs_write_i;

   // byte lane 0 write to one of the narrow registers
   function automatic logic qec_lo_wr(input logic hit, input logic [QEC_AW-1:0] a, input logic [QEC_AW-1:0] ofs,
      input logic [3:0] be);
      return hit && (a == ofs) && be[0];
   endfunction : qec_lo_wr

   // prev matches clean after reset, so no false first edge
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         prev_q <= 3'h0;
      end else begin
         prev_q <= ch.clean;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         pos_int_q <= 32'h0;
         pos_frac_q <= 16'h0;
      end else if (do_clear) begin
         pos_int_q <= 32'h0;
         pos_frac_q <= 16'h0;
      end else if (wr_hit && avs_address_i == QEC_OFS_POSITION) begin
         // a load drops the fraction, software sees whole counts
         pos_int_q <= qec_merge(pos_int_q, avs_writedata_i, avs_byteenable_i);
         pos_frac_q <= 16'h0;
      end else if (step) begin
         pos_int_q <= nxt_int;
         pos_frac_q <= nxt_frac;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         capture_q <= 32'h0;
      end else if (idx_act) begin
         capture_q <= pos_int_q;
      end
   end

   // data registers take every byte lane
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         scale_q <= QEC_RST_SCALE;
         dev_limit_q <= QEC_RST_DEV_LIMIT;
         motor_pos_q <= 32'h0;
      end else if (wr_hit) begin
         unique case (avs_address_i)
            QEC_OFS_SCALE: scale_q <= qec_merge(scale_q, avs_writedata_i, avs_byteenable_i);
            QEC_OFS_DEV_LIMIT: dev_limit_q <= qec_merge(dev_limit_q, avs_writedata_i, avs_byteenable_i);
            QEC_OFS_MOTOR_POS: motor_pos_q <= qec_merge(motor_pos_q, avs_writedata_i, avs_byteenable_i);
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         global_config_q <= 1'b0;
      end else if (qec_lo_wr(wr_hit, avs_address_i, QEC_OFS_GLOBAL_CONFIG, avs_byteenable_i)) begin
         global_config_q <= avs_writedata_i[0:0];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         irq_mask_q <= '0;
      end else if (qec_lo_wr(wr_hit, avs_address_i, QEC_OFS_IRQ_MASK, avs_byteenable_i)) begin
         irq_mask_q <= avs_writedata_i[QEC_IRQ_W-1:0];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         encoder_config_q <= QEC_RST_ECF;
      end else begin
         if (qec_lo_wr(wr_hit, avs_address_i, QEC_OFS_ENCODER_CONFIG, avs_byteenable_i)) begin
            encoder_config_q <= avs_writedata_i[QEC_ECF_W-1:0];
         end
         // the consumed shot beats a rewrite landing in the same cycle
         if (idx_act && encoder_config_q[QEC_ECF_CLR_ONCE]) begin
            encoder_config_q[QEC_ECF_CLR_ONCE] <= 1'b0;
         end
      end
   end

   // deviation compare
   // difference taken modulo 2^32 so wrapped positions still compare
   function automatic logic qec_over(input logic [31:0] p, input logic [31:0] m, input logic [31:0] lim);
      logic [31:0] d;
      d = p - m;
      if (d[31]) begin
         d = 32'(-d);
      end
      return d > lim;
   endfunction : qec_over

   logic over;
   assign over = qec_over(pos_int_q, motor_pos_q, dev_limit_q);
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         dev_q <= 1'b0;
      end else begin
         dev_q <= over;
      end
   end

   // sticky event status, set wins over clear
   logic [QEC_IRQ_W-1:0] ev;
   logic [QEC_IRQ_W-1:0] clr;
   always_comb begin
      ev = '0;
      ev[QEC_IRQ_INDEX] = idx_ok;
      ev[QEC_IRQ_CLEARED] = do_clear;
      // level from comparator: rising into mismatch only
      ev[QEC_IRQ_DEV] = over && !dev_q;
      clr = '0;
      if (qec_lo_wr(wr_hit, avs_address_i, QEC_OFS_IRQ_STATUS, avs_byteenable_i)) begin
         clr = avs_writedata_i[QEC_IRQ_W-1:0];
      end
   end
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         irq_status_q <= '0;
      end else begin
         irq_status_q <= (irq_status_q & ~clr) | ev;
      end
   end
   // interrupt output
   // registered so the pin never shows decode glitches
   logic irq_q;
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(irq_status_q & irq_mask_q);
      end
   end
   assign irq_o = irq_q;

   logic [31:0] rd_mux;
   always_comb begin
      unique case (avs_address_i)
         QEC_OFS_GLOBAL_CONFIG: rd_mux = {31'h0, global_config_q};
         QEC_OFS_ENCODER_CONFIG: rd_mux = {25'h0, encoder_config_q};
         QEC_OFS_POSITION: rd_mux = pos_int_q;
         QEC_OFS_SCALE: rd_mux = scale_q;
         QEC_OFS_CAPTURE: rd_mux = capture_q;
         QEC_OFS_DEV_LIMIT: rd_mux = dev_limit_q;
         QEC_OFS_IRQ_STATUS: rd_mux = {29'h0, irq_status_q};
         QEC_OFS_IRQ_MASK: rd_mux = {29'h0, irq_mask_q};
         QEC_OFS_MOTOR_POS: rd_mux = motor_pos_q;
         // unmapped offsets read as zero
         default: rd_mux = 32'h0;
      endcase
   end

   // one wait cycle keeps read data registered
   // trade: every access costs two clocks
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         bus_q <= QEC_BUS_IDLE;
         rdata_q <= 32'h0;
      end else begin
         unique case (bus_q)
            QEC_BUS_IDLE: begin
               if (avs_read_i || avs_write_i) begin
                  bus_q <= QEC_BUS_ACK;
                  rdata_q <= avs_read_i ? rd_mux : 32'h0;
               end
            end
            QEC_BUS_ACK: bus_q <= QEC_BUS_IDLE;
            default: bus_q <= QEC_BUS_IDLE;
         endcase
      end
   end
   assign avs_waitrequest_o = (bus_q != QEC_BUS_ACK);
   assign avs_readdata_o = rdata_q;
endmodule : qec_counter
`default_nettype wire

// ===== design/qec_pkg.sv
// package of constants and types for the quadrature encoder counter
`default_nettype none
package qec_pkg;
   localparam int unsigned QEC_AW = 6;
   localparam logic [QEC_AW-1:0] QEC_OFS_GLOBAL_CONFIG = 6'h00;
   localparam logic [QEC_AW-1:0] QEC_OFS_ENCODER_CONFIG = 6'h04;
   localparam logic [QEC_AW-1:0] QEC_OFS_POSITION = 6'h08;
   localparam logic [QEC_AW-1:0] QEC_OFS_SCALE = 6'h0C;
   localparam logic [QEC_AW-1:0] QEC_OFS_CAPTURE = 6'h10;
   localparam logic [QEC_AW-1:0] QEC_OFS_DEV_LIMIT = 6'h14;
   localparam logic [QEC_AW-1:0] QEC_OFS_IRQ_STATUS = 6'h18;
   localparam logic [QEC_AW-1:0] QEC_OFS_IRQ_MASK = 6'h1C;
   localparam logic [QEC_AW-1:0] QEC_OFS_MOTOR_POS = 6'h20;
   // encoder_config fields
   localparam int unsigned QEC_ECF_POL_A = 0;
   localparam int unsigned QEC_ECF_POL_B = 1;
   localparam int unsigned QEC_ECF_POL_N = 2;
   localparam int unsigned QEC_ECF_CLR_CONT = 3;
   localparam int unsigned QEC_ECF_CLR_ONCE = 4;
   localparam int unsigned QEC_ECF_CLR_POS = 5;
   localparam int unsigned QEC_ECF_DECIMAL = 6;
   localparam int unsigned QEC_ECF_W = 7;
   // global_config fields
   localparam int unsigned QEC_GCF_ENC_SEL = 0;
   // irq status fields
   localparam int unsigned QEC_IRQ_INDEX = 0;
   localparam int unsigned QEC_IRQ_CLEARED = 1;
   localparam int unsigned QEC_IRQ_DEV = 2;
   localparam int unsigned QEC_IRQ_W = 3;
   // reset values
   localparam logic [31:0] QEC_RST_SCALE = 32'h0001_0000;
   localparam logic [31:0] QEC_RST_DEV_LIMIT = 32'h0000_0000;
   localparam logic [QEC_ECF_W-1:0] QEC_RST_ECF = 7'h00;
   // timing: filter length in clock periods, decimal fraction base
   localparam int unsigned QEC_FILT_CYC = 3;
   localparam logic [15:0] QEC_DEC_BASE = 16'h2710;
   typedef enum logic [1:0] {
      QEC_BUS_IDLE = 2'b01,
      QEC_BUS_ACK = 2'b10
   } qec_bus_state_t;
endpackage : qec_pkg
`default_nettype wire

// ===== design/qec_filt_if.sv
// interface carrying raw and filtered encoder channels between modules
`default_nettype none
interface qec_filt_if;
   logic [2:0] raw;
   logic [2:0] clean;
   modport filt (input raw, output clean);
   modport user (output raw, input clean);
endinterface : qec_filt_if
`default_nettype wire

// ===== design/qec_input_filter.sv
// synchroniser and spike filter for the A, B and index inputs
`default_nettype none
module qec_input_filter #(
   parameter int unsigned FILT_CYC = qec_pkg::QEC_FILT_CYC
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   qec_filt_if.filt ch
);
   import qec_pkg::*;
   logic [2:0] s1_q;
   logic [2:0] s2_q;
   logic [2:0] s3_q;
   logic [2:0] clean_q;
   logic [1:0] cnt_q [3];
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         s1_q <= 3'h0;
         s2_q <= 3'h0;
         s3_q <= 3'h0;
      end else begin
         s1_q <= ch.raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         clean_q <= 3'h0;
         for (int i = 0; i < 3; i++) begin
            cnt_q[i] <= 2'h0;
         end
      end else begin
         for (int i = 0; i < 3; i++) begin
            // only a level agreed by stages two and three counts
            if (s2_q[i] != s3_q[i] || s3_q[i] == clean_q[i]) begin
               cnt_q[i] <= 2'h0;
            end else if (cnt_q[i] == 2'(FILT_CYC - 1)) begin
               cnt_q[i] <= 2'h0;
               clean_q[i] <= s3_q[i];
            end else begin
               cnt_q[i] <= cnt_q[i] + 2'h1;
            end
         end
      end
   end
   assign ch.clean = clean_q;
endmodule : qec_input_filter
`default_nettype wire

// ===== bench/qec_counter_assertions.sv
// checker for the bus handshake and interrupt of the encoder counter
`default_nettype none
module qec_counter_assertions (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic enc_a_i,
   input wire logic enc_b_i,
   input wire logic enc_n_i,
   input wire logic [qec_pkg::QEC_AW-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic irq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import qec_pkg::*;
   logic sc_w_q;
   logic [2:0] mask_q;
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // shadow of scale and mask writes, taken at the taking edge
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         sc_w_q <= 1'b0;
         mask_q <= 3'h0;
      end else if (avs_write_i && avs_waitrequest_o) begin
         if (avs_address_i == QEC_OFS_SCALE) begin
            sc_w_q <= 1'b1;
         end
         if (avs_address_i == QEC_OFS_IRQ_MASK) begin
            mask_q <= avs_writedata_i[2:0];
         end
      end
   end
   sequence taken_s;
      (avs_read_i || avs_write_i) && avs_waitrequest_o;
   endsequence
   sequence ack_s;
      !avs_waitrequest_o ##1 avs_waitrequest_o;
   endsequence
   chk_ack_follows: assert property (taken_s |=> ack_s)
      else $error("no single ack after request");
   chk_ack_needs_req: assert property ($fell(avs_waitrequest_o) |-> $past(avs_read_i) || $past(avs_write_i))
      else $error("ack without request");
   chk_idle_wait: assert property (!avs_read_i && !avs_write_i |=> avs_waitrequest_o)
      else $error("waitrequest low while idle");
   chk_rdata_hold: assert property (!$stable(avs_readdata_o) |-> !avs_waitrequest_o)
      else $error("read data moved outside ack");
   chk_unmapped_zero: assert property (avs_read_i && avs_waitrequest_o && avs_address_i > QEC_OFS_MOTOR_POS
      |=> avs_readdata_o == 32'h0)
      else $error("unmapped read not zero");
   chk_scale_reset: assert property (avs_read_i && avs_waitrequest_o && avs_address_i == QEC_OFS_SCALE && !sc_w_q
      |=> avs_readdata_o == QEC_RST_SCALE)
      else $error("scale reset value wrong");
   chk_irq_fall_write: assert property ($fell(irq_o) |-> $past(avs_write_i) || $past(avs_write_i, 2))
      else $error("irq dropped without write");
   chk_irq_masked: assert property ((mask_q == 3'h0) [*3] |-> !irq_o)
      else $error("irq while all masked");
endmodule : qec_counter_assertions
bind qec_counter qec_counter_assertions u_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .enc_a_i(enc_a_i),
   .enc_b_i(enc_b_i), .enc_n_i(enc_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
   .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o));
`default_nettype wire

// ===== bench/qec_encoder_model.sv
// behavioural incremental encoder with A, B and index outputs
`default_nettype none
module qec_encoder_model (
   input wire logic clk_i,
   output logic a_o,
   output logic b_o,
   output logic n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int ph = 0;
   initial begin
      a_o = 1'b0;
      b_o = 1'b0;
      n_o = 1'b0;
   end
   // levels held six clocks at least
   task automatic step(input bit fwd, input int gap);
      ph = fwd ? (ph + 1) % 4 : (ph + 3) % 4;
      a_o <= (ph == 1 || ph == 2);
      b_o <= (ph >= 2);
      repeat (gap < 6 ? 6 : gap) @(posedge clk_i);
   endtask : step
   task automatic pulse();
      n_o <= 1'b1;
      repeat (8) @(posedge clk_i);
      n_o <= 1'b0;
      repeat (8) @(posedge clk_i);
   endtask : pulse
   // short pulse on A the filter must swallow
   task automatic spike(input int len);
      a_o <= ~a_o;
      repeat (len) @(posedge clk_i);
      a_o <= ~a_o;
      repeat (8) @(posedge clk_i);
   endtask : spike
   // both channels move together, no count
   task automatic jump();
      ph = (ph + 2) % 4;
      a_o <= (ph == 1 || ph == 2);
      b_o <= (ph >= 2);
      repeat (8) @(posedge clk_i);
   endtask : jump
endmodule : qec_encoder_model
`default_nettype wire

// ===== bench/qec_counter_bench.sv
// self-checking bench for the quadrature encoder counter
`default_nettype none
module qec_counter_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import qec_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic rd = 1'b0;
   logic wt = 1'b0;
   logic [QEC_AW-1:0] adr = 6'h00;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdat;
   logic wreq;
   logic irq;
   logic ea;
   logic eb;
   logic en;
   int err_total = 0;
   int tests_run = 0;
   int ipos = 0;
   int frac = 0;
   int cap = 0;
   bit dec = 1'b0;
   logic [31:0] sc = 32'h0001_0000;
   logic [31:0] lf = 32'h0001_71CE;
   logic [31:0] q;
   logic [31:0] tbl [4] = '{32'hFFFF_0000, 32'h0001_8000, 32'h0019_1770, 32'hFFE6_0FA0};
   always #4 clk = ~clk;
   qec_counter u_dut (.ref_clk_i(clk), .rst_n_i(rst_n), .enc_a_i(ea), .enc_b_i(eb), .enc_n_i(en),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wt), .avs_writedata_i(wd),
      .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .irq_o(irq));
   qec_encoder_model u_enc (.clk_i(clk), .a_o(ea), .b_o(eb), .n_o(en));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // request held until waitrequest is sampled low
   task automatic bus(input bit w, input logic [QEC_AW-1:0] a, input logic [31:0] d);
      @(posedge clk);
      rd <= !w;
      wt <= w;
      adr <= a;
      wd <= d;
      do @(posedge clk); while (wreq !== 1'b0);
      q = rdat;
      rd <= 1'b0;
      wt <= 1'b0;
   endtask : bus
   // reference accumulator: signed integer part, fraction carried at base
   task automatic mv(input bit fwd, input int n);
      int base;
      int hi;
      int lo;
      base = dec ? 10000 : 65536;
      hi = $signed(sc[31:16]);
      lo = int'(sc[15:0]);
      repeat (n) begin
         u_enc.step(fwd, 6);
         ipos += fwd ? hi : -hi;
         frac += fwd ? lo : -lo;
         if (frac >= base) begin
            frac -= base;
            ipos++;
         end
         if (frac < 0) begin
            frac += base;
            ipos--;
         end
      end
   endtask : mv
   // filter and synchroniser latency is well under ten clocks
   task automatic pchk();
      repeat (10) @(posedge clk);
      bus(1'b0, QEC_OFS_POSITION, 32'h0);
      chk("position", q, ipos);
   endtask : pchk
   task automatic ichk(input logic e);
      repeat (5) @(posedge clk);
      chk("irq", {31'h0, irq}, {31'h0, e});
   endtask : ichk
   task automatic setpos(input int p);
      bus(1'b1, QEC_OFS_POSITION, p);
      ipos = p;
      frac = 0;
   endtask : setpos
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict
   initial begin
      #200us;
      err_total++;
      print_verdict();
   end
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b0, QEC_OFS_SCALE, 32'h0);
      chk("scale", q, QEC_RST_SCALE);
      bus(1'b0, 6'h3C, 32'h0);
      chk("unmapped", q, 32'h0);
      repeat (4) u_enc.step(1'b1, 6);
      pchk();
      $display("test select done");
      bus(1'b1, QEC_OFS_GLOBAL_CONFIG, 32'h1);
      repeat (30) begin
         lf = lfsr(lf);
         mv(lf[0], 1 + int'(lf[3:1]));
      end
      pchk();
      u_enc.spike(2);
      u_enc.jump();
      pchk();
      $display("test random done");
      foreach (tbl[i]) begin
         sc = tbl[i];
         dec = (i >= 2);
         bus(1'b1, QEC_OFS_ENCODER_CONFIG, {25'h0, dec, 6'h00});
         bus(1'b1, QEC_OFS_SCALE, sc);
         setpos(0);
         mv(1'b1, 7);
         mv(1'b0, 3);
         pchk();
      end
      $display("test scale done");
      sc = 32'h0001_0000;
      dec = 1'b0;
      bus(1'b1, QEC_OFS_SCALE, sc);
      bus(1'b1, QEC_OFS_ENCODER_CONFIG, 32'h2F);
      while (u_enc.ph != 2) mv(1'b1, 1);
      setpos(5);
      repeat (2) begin
         cap = ipos;
         u_enc.pulse();
         bus(1'b0, QEC_OFS_CAPTURE, 32'h0);
         chk("capture", q, cap);
         ipos = 0;
         pchk();
         mv(1'b1, 4);
      end
      bus(1'b0, QEC_OFS_IRQ_STATUS, 32'h0);
      chk("status", q & 32'h3, 32'h3);
      mv(1'b1, 1);
      u_enc.pulse();
      pchk();
      bus(1'b1, QEC_OFS_ENCODER_CONFIG, 32'h37);
      mv(1'b0, 1);
      mv(1'b1, 4);
      u_enc.pulse();
      ipos = 0;
      pchk();
      bus(1'b0, QEC_OFS_ENCODER_CONFIG, 32'h0);
      chk("shot", q, 32'h27);
      mv(1'b1, 4);
      u_enc.pulse();
      pchk();
      $display("test index done");
      bus(1'b1, QEC_OFS_MOTOR_POS, ipos);
      bus(1'b1, QEC_OFS_DEV_LIMIT, 32'h3);
      bus(1'b1, QEC_OFS_IRQ_STATUS, 32'h7);
      bus(1'b1, QEC_OFS_IRQ_MASK, 32'h4);
      ichk(1'b0);
      mv(1'b1, 4);
      ichk(1'b1);
      bus(1'b1, QEC_OFS_IRQ_STATUS, 32'h4);
      ichk(1'b0);
      bus(1'b1, QEC_OFS_IRQ_MASK, 32'h0);
      mv(1'b0, 8);
      ichk(1'b0);
      bus(1'b0, QEC_OFS_IRQ_STATUS, 32'h0);
      chk("deviation", q & 32'h4, 32'h4);
      bus(1'b1, QEC_OFS_IRQ_MASK, 32'h4);
      ichk(1'b1);
      $display("test deviation done");
      print_verdict();
   end
endmodule : qec_counter_bench
`default_nettype wire
